// *** ssr_pkg.sv ***
// Shared constants and request layout for the synchronous SRAM block
package ssr_pkg;

    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 10;
    localparam int DEPTH = 4096;

    // ************************************************************
    // Control encodings (all three controls are active low)
    // ************************************************************
    localparam logic SEL_ON = 1'h0;
    localparam logic SEL_OFF = 1'h1;
    localparam logic WR_ON = 1'h0;
    localparam logic WR_OFF = 1'h1;
    localparam logic OE_DRIVE = 1'h0;
    localparam logic OE_FLOAT = 1'h1;

    // ************************************************************
    // Access kinds decoded from a registered request
    // ************************************************************
    typedef enum logic [1:0] {
        SSR_IDLE,
        SSR_READ,
        SSR_WRITE
    } ssr_op_type;

    // ************************************************************
    // One registered request
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic wr_n;
        logic sel_n;
    } ssr_req_type;

    localparam ssr_req_type REQ_IDLE = '{addr: '0, data: '0, wr_n: WR_OFF, sel_n: SEL_OFF};

endpackage : ssr_pkg

// *** ssr_mem.sv ***
// Storage array with write port and registered read data
`timescale 1ns/100ps
module ssr_mem #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 10,
    parameter int DEPTH = 4096
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data_ff
);

    // ************************************************************
    // Array, no clear on reset: contents stay undefined until written
    // ************************************************************
    logic [DATA_W-1:0] mem_ff [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_ff[addr] <= wr_data;
        end
    end

    // Read data register only loads on reads, so it keeps the last read word
    always_ff @(posedge ref_clk) begin
        if (rd_en) begin
            rd_data_ff <= mem_ff[addr];
        end
    end

endmodule : ssr_mem

// *** ssr_top.sv ***
// Synchronous 4K x 10 SRAM with input registers and pipelined output register
`timescale 1ns/100ps
module ssr_top #(
    parameter int ADDR_W = ssr_pkg::ADDR_W,
    parameter int DATA_W = ssr_pkg::DATA_W,
    parameter int DEPTH = ssr_pkg::DEPTH
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] din_bus,
    input wire logic wr_n,
    input wire logic sel_n,
    output logic [DATA_W-1:0] dout_bus,
    output logic dout_oe_n,
    output logic standby
);

    // ************************************************************
    // Input registers
    // ************************************************************
    ssr_pkg::ssr_req_type req_ff;
    ssr_pkg::ssr_req_type nxt_req;
    logic oe_n_ff;
    logic standby_ff;
    ssr_pkg::ssr_op_type op;
    wire logic is_sel;
    wire logic do_read;
    wire logic do_write;

    assign nxt_req = '{addr: addr_in, data: din_bus, wr_n: wr_n, sel_n: sel_n};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_ff <= ssr_pkg::REQ_IDLE;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // ************************************************************
    // Access decode
    // ************************************************************
    // deselect blocks any access
    assign is_sel = (req_ff.sel_n == ssr_pkg::SEL_ON);

    always_comb begin
        case ({is_sel, req_ff.wr_n})
            {1'h1, ssr_pkg::WR_ON}: op = ssr_pkg::SSR_WRITE;
            {1'h1, ssr_pkg::WR_OFF}: op = ssr_pkg::SSR_READ;
            default: op = ssr_pkg::SSR_IDLE;
        endcase
    end

    assign do_read = (op == ssr_pkg::SSR_READ);
    assign do_write = (op == ssr_pkg::SSR_WRITE);

    // ************************************************************
    // Array and output register
    // ************************************************************
    // array geometry
    // write done in one internal clock edge
    ssr_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .DEPTH(DEPTH)
    ) u_mem (
        .ref_clk(ref_clk),
        .wr_en(do_write),
        .rd_en(do_read),
        .addr(req_ff.addr),
        .wr_data(req_ff.data),
        .rd_data_ff(dout_bus)
    );

    // ************************************************************
    // Output enable and standby
    // ************************************************************
    // drive only after reads
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            oe_n_ff <= ssr_pkg::OE_FLOAT;
            standby_ff <= 1'h1;
        end else begin
            oe_n_ff <= do_read ? ssr_pkg::OE_DRIVE : ssr_pkg::OE_FLOAT;
            standby_ff <= ~is_sel;
        end
    end

    assign dout_oe_n = oe_n_ff;
    assign standby = standby_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    // Single-slot requests as seen on the pins
    sequence s_read_in;
        sel_n == ssr_pkg::SEL_ON && wr_n == ssr_pkg::WR_OFF;
    endsequence

    sequence s_write_in;
        sel_n == ssr_pkg::SEL_ON && wr_n == ssr_pkg::WR_ON;
    endsequence

    sequence s_desel_in;
        sel_n == ssr_pkg::SEL_OFF;
    endsequence

    // Slot that cannot disturb the word written one slot earlier
    sequence s_other_slot;
        s_desel_in or (s_write_in and (addr_in != $past(addr_in)));
    endsequence

    // ************************************************************
    // Multi-slot access patterns
    // ************************************************************
    sequence s_write_read_same;
        s_write_in ##1 (s_read_in and (addr_in == $past(addr_in)));
    endsequence

    sequence s_write_gap_read;
        s_write_in ##1 s_other_slot ##1 (s_read_in and (addr_in == $past(addr_in, 2)));
    endsequence

    sequence s_read_desel;
        s_read_in ##1 s_desel_in;
    endsequence

    sequence s_read_write;
        s_read_in ##1 s_write_in;
    endsequence

    // ************************************************************
    // Property checks
    // ************************************************************
    chk_read_drives: assert property (@(posedge ref_clk) disable iff (srst)
        s_read_in ##1 !srst |=> dout_oe_n == ssr_pkg::OE_DRIVE)
        else $error("read did not drive outputs");

    chk_write_floats: assert property (@(posedge ref_clk) disable iff (srst)
        s_write_in ##1 !srst |=> dout_oe_n == ssr_pkg::OE_FLOAT)
        else $error("write left outputs driven");

    chk_desel_floats: assert property (@(posedge ref_clk) disable iff (srst)
        s_desel_in ##1 1'h1 |=> dout_oe_n == ssr_pkg::OE_FLOAT && standby)
        else $error("deselect did not float and idle");

    chk_desel_no_change: assert property (@(posedge ref_clk) disable iff (srst)
        s_read_desel ##1 1'h1 |=> $stable(dout_bus))
        else $error("output register changed while deselected");

    chk_write_read_back: assert property (@(posedge ref_clk) disable iff (srst)
        s_write_read_same ##2 1'h1 |-> dout_bus == $past(din_bus, 3))
        else $error("read after write returned wrong word");

    chk_write_gap_read: assert property (@(posedge ref_clk) disable iff (srst)
        s_write_gap_read ##2 1'h1 |-> dout_bus == $past(din_bus, 4))
        else $error("read two slots after write returned wrong word");

    chk_hold_last_read: assert property (@(posedge ref_clk) disable iff (srst)
        s_read_write ##1 1'h1 |=> dout_bus == $past(dout_bus))
        else $error("output changed without a read");

    chk_read_pair: assert property (@(posedge ref_clk) disable iff (srst)
        s_read_in ##1 s_read_in ##1 1'h1 |=> dout_oe_n == ssr_pkg::OE_DRIVE)
        else $error("second read in a row did not keep outputs driven");

    chk_pipe_latency: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(dout_oe_n) |->
        $past(sel_n, 2) == ssr_pkg::SEL_ON && $past(wr_n, 2) == ssr_pkg::WR_OFF)
        else $error("output enabled without read two edges before");

    chk_read_awake: assert property (@(posedge ref_clk) disable iff (srst)
        s_read_in ##1 1'h1 |=> !standby)
        else $error("standby set during a read");

    chk_write_awake: assert property (@(posedge ref_clk) disable iff (srst)
        s_write_in ##1 1'h1 |=> !standby)
        else $error("standby set during a write");

    chk_desel_no_write: assert property (@(posedge ref_clk) disable iff (srst)
        do_write |-> $past(sel_n) == ssr_pkg::SEL_ON && $past(wr_n) == ssr_pkg::WR_ON)
        else $error("array written without a selected write");

    chk_read_decode: assert property (@(posedge ref_clk) disable iff (srst)
        do_read |-> $past(sel_n) == ssr_pkg::SEL_ON && $past(wr_n) == ssr_pkg::WR_OFF)
        else $error("array read without a selected read");

    chk_reset_float: assert property (@(posedge ref_clk)
        srst |=> dout_oe_n == ssr_pkg::OE_FLOAT)
        else $error("outputs not floating after reset");

    chk_reset_idle: assert property (@(posedge ref_clk)
        srst |=> standby && req_ff.sel_n == ssr_pkg::SEL_OFF)
        else $error("request register not idle after reset");

    chk_capture_edge: assert property (@(posedge ref_clk) disable iff (srst)
        1'h1 |=> req_ff.addr == $past(addr_in) && req_ff.data == $past(din_bus))
        else $error("input register did not capture");

    chk_capture_ctrl: assert property (@(posedge ref_clk) disable iff (srst)
        1'h1 |=> req_ff.sel_n == $past(sel_n) && req_ff.wr_n == $past(wr_n))
        else $error("control register did not capture");

endmodule : ssr_top

// *** ssr_ctl_model.sv ***
// Controller model driving the synchronous SRAM request inputs
`timescale 1ns/100ps
module ssr_ctl_model (
    input wire logic ref_clk,
    output logic [ssr_pkg::ADDR_W-1:0] addr_in,
    output logic [ssr_pkg::DATA_W-1:0] din_bus,
    output logic wr_n,
    output logic sel_n
);
    initial begin
        addr_in = 12'h000;
        din_bus = 10'h000;
        wr_n = ssr_pkg::WR_OFF;
        sel_n = ssr_pkg::SEL_OFF;
    end

    task automatic drive(input logic s, input logic w, input logic [11:0] a,
                         input logic [9:0] d);
        @(negedge ref_clk);
        sel_n = s;
        wr_n = w;
        addr_in = a;
        din_bus = d;
    endtask : drive

    // Deselected lines flip so stale values never look valid
    task automatic idle;
        drive(ssr_pkg::SEL_OFF, ~wr_n, ~addr_in, ~din_bus);
    endtask : idle
endmodule : ssr_ctl_model

// *** tb_top.sv ***
// Self-checking bench for the synchronous SRAM block
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'h0;
    logic srst = 1'h1;
    logic [11:0] addr_in;
    logic [9:0] din_bus;
    logic wr_n;
    logic sel_n;
    logic [9:0] dout_bus;
    logic dout_oe_n;
    logic standby;
    int err_count = 0;
    int compares = 0;

    always #2.5 ref_clk = ~ref_clk;

    ssr_ctl_model ssr_ctl_model_i (.ref_clk(ref_clk), .addr_in(addr_in), .din_bus(din_bus),
        .wr_n(wr_n), .sel_n(sel_n));
    ssr_top ssr_top_i (.ref_clk(ref_clk), .srst(srst), .addr_in(addr_in), .din_bus(din_bus),
        .wr_n(wr_n), .sel_n(sel_n), .dout_bus(dout_bus), .dout_oe_n(dout_oe_n),
        .standby(standby));

    task automatic cmp_word(input string nm, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_flag

    task automatic check_read(input logic [11:0] a, input logic [9:0] e);
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_OFF, a, ~e);
        cmp_flag("float", ssr_pkg::OE_FLOAT, dout_oe_n);
        ssr_ctl_model_i.idle();
        @(negedge ref_clk);
        cmp_word("read data", e, dout_bus);
        cmp_flag("drive", ssr_pkg::OE_DRIVE, dout_oe_n);
        cmp_flag("standby", 1'h0, standby);
    endtask : check_read

    task automatic t_reset;
        repeat (2) @(negedge ref_clk);
        cmp_flag("oe at start", ssr_pkg::OE_FLOAT, dout_oe_n);
        cmp_flag("standby at start", 1'h1, standby);
        srst = 1'h0;
    endtask : t_reset

    task automatic t_wr_rd;
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_ON, 12'h000, 10'h2A5);
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_ON, 12'hFFF, 10'h15A);
        check_read(12'h000, 10'h2A5);
        check_read(12'hFFF, 10'h15A);
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_ON, 12'h7FF, 10'h3C3);
        check_read(12'h7FF, 10'h3C3);
    endtask : t_wr_rd

    task automatic t_desel;
        ssr_ctl_model_i.drive(ssr_pkg::SEL_OFF, ssr_pkg::WR_ON, 12'hFFF, 10'h0F0);
        ssr_ctl_model_i.idle();
        @(negedge ref_clk);
        cmp_flag("standby", 1'h1, standby);
        cmp_flag("oe deselected", ssr_pkg::OE_FLOAT, dout_oe_n);
        check_read(12'hFFF, 10'h15A);
    endtask : t_desel

    task automatic t_rd_wr;
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_OFF, 12'h000, 10'h3FF);
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_OFF, 12'hFFF, 10'h3FF);
        ssr_ctl_model_i.drive(ssr_pkg::SEL_ON, ssr_pkg::WR_ON, 12'h000, 10'h0F0);
        cmp_word("first of pair", 10'h2A5, dout_bus);
        ssr_ctl_model_i.idle();
        cmp_word("second of pair", 10'h15A, dout_bus);
        cmp_flag("pair drive", ssr_pkg::OE_DRIVE, dout_oe_n);
        @(negedge ref_clk);
        cmp_word("held word", 10'h15A, dout_bus);
        cmp_flag("oe after write", ssr_pkg::OE_FLOAT, dout_oe_n);
        check_read(12'h000, 10'h0F0);
    endtask : t_rd_wr

    task automatic end_sim;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    initial begin
        t_reset();
        t_wr_rd();
        t_desel();
        t_rd_wr();
        end_sim();
    end

    initial begin
        #1000;
        err_count++;
        end_sim();
    end
endmodule : tb_top
